// ---- hdl/amssc_top.sv ----
// Two-axis command handling: velocity switch, stop and position sync
module amssc_top (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [1:0]   indirect_start_request,
  input  wire logic [1:0]   direct_start_request,
  input  wire logic [1:0]   origin_ok,
  input  wire logic [1:0][31:0] cur_pos,
  input  wire logic [1:0][31:0] step_target,
  input  wire logic [1:0]   step_abs,
  input  wire logic [1:0][3:0] step_profile,
  input  wire logic [1:0]   step_mcode,
  input  wire logic [1:0][31:0] dst_amount,
  input  wire logic [1:0][3:0] dst_profile,
  input  wire logic [1:0]   gen_done,
  output logic              cmd_done,
  output logic [15:0]       cmd_status,
  output logic              x_pos_control_flag,
  output logic              y_pos_control_flag,
  output logic              x_in_operation_flag,
  output logic              y_in_operation_flag,
  output logic              x_positioning_done_flag,
  output logic              y_positioning_done_flag,
  output logic [1:0]        m_code_on,
  output logic [1:0]        pulse_enable,
  output logic [1:0]        decel_start,
  output logic [amssc_pkg::CTRL_AXIS*4-1:0] decel_time,
  output logic [1:0][3:0]   accdec_profile,
  output logic [1:0]        sync_go,
  output logic [1:0][6:0]   cur_step,
  output logic [1:0][31:0]  move_amount
);
  import amssc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  amssc_st_t        st_r [2];
  logic [4:0]       ctrl_r, ctrl_q_r;
  logic [15:0]      decel_time_operand_r;
  logic [15:0]      sync_r;
  logic [31:0]      main_axis_trigger_pos_r;
  logic [15:0]      stat_r;
  logic             done_r;
  logic [1:0]       ist_q_r, dst_q_r;
  logic [1:0]       vel_r, pdone_r, mcode_r, pen_r, dreq_r, go_r;
  logic [1:0]       main_r;
  logic [1:0][31:0] trg_r, move_r;
  logic [1:0][3:0]  prof_r;
  logic [1:0][6:0]  step_r;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire s_ctrl   = paddr == A_CTRL;
  wire s_dec    = paddr == A_DECEL;
  wire s_sync   = paddr == A_SYNC;
  wire s_trig   = paddr == A_TRIG;
  wire s_stat   = paddr == A_STAT;
  wire s_flags  = paddr == A_FLAGS;
  wire hit      = s_ctrl | s_dec | s_sync | s_trig | s_stat | s_flags;
  wire [1:0] in_op;
  wire [7:0] flags = {main_r, pdone_r, in_op, ~vel_r & in_op};

  // Zero-wait slave; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = s_ctrl  ? {27'h000_0000, ctrl_r} :
                   s_dec   ? {16'h0000, decel_time_operand_r} :
                   s_sync  ? {16'h0000, sync_r} :
                   s_trig  ? main_axis_trigger_pos_r :
                   s_stat  ? {15'h0000, done_r, stat_r} :
                   s_flags ? {24'h00_0000, flags} : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Command edges; stop wins over velocity switch over sync
  // ---------------------------------------------------------------
  wire [4:0] rise = ctrl_r & ~ctrl_q_r;
  wire ax = ctrl_r[CTRL_AXIS];
  wire decel_stop_request = rise[CTRL_STP];
  wire pos_to_vel_request = rise[CTRL_PTV] & ~decel_stop_request;
  wire pos_sync_start_request = rise[CTRL_SSP] & ~rise[CTRL_STP]
                              & ~rise[CTRL_PTV];
  wire cmd_any = decel_stop_request | pos_to_vel_request
               | pos_sync_start_request;
  wire main_axis_select = sync_r[SYNC_MAIN];
  wire bad_main = |sync_r[15:9];
  wire dec_zero = decel_time_operand_r == DEC_RST;
  wire [1:0] ist_rise = indirect_start_request & ~ist_q_r;
  wire [1:0] dst_rise = direct_start_request & ~dst_q_r;

  // Sync start checks in priority order
  wire [15:0] ssp_err =
    bad_main                         ? ERR_MAIN_RNG :
    (main_axis_select == ax)         ? ERR_SAME :
    (st_r[main_axis_select] == ST_ARMED) ? ERR_MAIN_SUB :
    !origin_ok[main_axis_select]     ? ERR_MAIN_ORG :
    !origin_ok[ax]                   ? ERR_SUB_ORG :
    (st_r[ax] != ST_IDLE)            ? ERR_SUB_BUSY : STAT_OK;

  // ---------------------------------------------------------------
  // Per-axis command select, move size and trigger compare
  // ---------------------------------------------------------------
  wire [1:0] stp_a, ptv_a, ssp_a, trig_hit;
  wire [1:0][31:0] ind_mv;
  for (genvar g = 0; g < 2; g++) begin : g_axis
    assign stp_a[g] = decel_stop_request & (ax == 1'(g));
    assign ptv_a[g] = pos_to_vel_request & (ax == 1'(g));
    assign ssp_a[g] = pos_sync_start_request & (ax == 1'(g))
                    & (ssp_err == STAT_OK);
    // Absolute step goes to target, incremental travels full amount
    assign ind_mv[g] = step_abs[g] ? step_target[g] - cur_pos[g]
                                   : step_target[g];
    // Signed trigger compare against the selected main axis
    assign trig_hit[g] = $signed(cur_pos[main_r[g]])
                      == $signed(trg_r[g]);
    assign in_op[g] = st_r[g] != ST_IDLE;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cmd_done                = done_r;
  assign cmd_status              = stat_r;
  assign x_pos_control_flag      = flags[0];
  assign y_pos_control_flag      = flags[1];
  assign x_in_operation_flag     = in_op[0];
  assign y_in_operation_flag     = in_op[1];
  assign x_positioning_done_flag = pdone_r[0];
  assign y_positioning_done_flag = pdone_r[1];
  assign m_code_on               = mcode_r;
  assign pulse_enable            = pen_r;
  assign decel_start             = dreq_r;
  assign decel_time              = decel_time_operand_r;
  assign accdec_profile          = prof_r;
  assign sync_go                 = go_r;
  assign cur_step                = step_r;
  assign move_amount             = move_r;

  // ---------------------------------------------------------------
  // Register file, done and status
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r                  <= 5'h00;
      ctrl_q_r                <= 5'h00;
      decel_time_operand_r    <= DEC_RST;
      sync_r                  <= 16'h0000;
      main_axis_trigger_pos_r <= 32'h0000_0000;
      stat_r                  <= STAT_OK;
      done_r                  <= 1'b0;
      ist_q_r                 <= 2'b00;
      dst_q_r                 <= 2'b00;
    end else begin
      ctrl_q_r <= ctrl_r;
      ist_q_r  <= indirect_start_request;
      dst_q_r  <= direct_start_request;
      if (wr && s_ctrl) ctrl_r <= pwdata[4:0];
      if (wr && s_dec) decel_time_operand_r <= pwdata[15:0];
      if (wr && s_sync) sync_r <= pwdata[15:0];
      if (wr && s_trig) main_axis_trigger_pos_r <= pwdata;
      done_r <= cmd_any;
      if (cmd_any) begin
        stat_r <= pos_sync_start_request ? ssp_err : STAT_OK;
      end
    end
  end

  // ---------------------------------------------------------------
  // Axis sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < 2; a++) begin
        st_r[a] <= ST_IDLE;
      end
      vel_r   <= 2'b00;
      pdone_r <= 2'b00;
      mcode_r <= 2'b00;
      pen_r   <= 2'b00;
      dreq_r  <= 2'b00;
      go_r    <= 2'b00;
      main_r  <= 2'b00;
      trg_r   <= '0;
      move_r  <= '0;
      prof_r  <= '0;
      step_r  <= '0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        dreq_r[a] <= 1'b0;
        go_r[a]   <= 1'b0;
        unique case (st_r[a])
          ST_IDLE: begin
            if (ssp_a[a]) begin
              st_r[a]   <= ST_ARMED;
              main_r[a] <= main_axis_select;
              trg_r[a]  <= main_axis_trigger_pos_r;
              step_r[a] <= sync_r[6:0];
              vel_r[a]  <= 1'b0;
              pdone_r[a] <= 1'b0;
            end else if (ist_rise[a] | dst_rise[a]) begin
              st_r[a]    <= ST_RUN;
              pen_r[a]   <= 1'b1;
              vel_r[a]   <= 1'b0;
              pdone_r[a] <= 1'b0;
              mcode_r[a] <= 1'b0;
              move_r[a]  <= dst_rise[a] ? dst_amount[a] : ind_mv[a];
              prof_r[a]  <= dst_rise[a] ? dst_profile[a]
                                        : step_profile[a];
            end
          end
          ST_RUN: begin
            if (stp_a[a] && dec_zero) begin
              st_r[a]  <= ST_IDLE;
              pen_r[a] <= 1'b0;
              vel_r[a] <= 1'b0;
            end else if (stp_a[a]) begin
              st_r[a]   <= ST_DECEL;
              dreq_r[a] <= 1'b1;
            end else if (ptv_a[a]) begin
              vel_r[a] <= 1'b1;
            end else if (gen_done[a] && !vel_r[a]) begin
              st_r[a]    <= ST_IDLE;
              pen_r[a]   <= 1'b0;
              pdone_r[a] <= 1'b1;
              mcode_r[a] <= step_mcode[a];
              if (step_r[a] != STEP_MAX) begin
                step_r[a] <= step_r[a] + 7'h01;
              end
            end
          end
          ST_DECEL: begin
            // Ends with no done flag, no M code and step kept
            if (gen_done[a] || (stp_a[a] && dec_zero)) begin
              st_r[a]  <= ST_IDLE;
              pen_r[a] <= 1'b0;
              vel_r[a] <= 1'b0;
            end
          end
          ST_ARMED: begin
            if (stp_a[a]) begin
              st_r[a] <= ST_IDLE;
            end else if (trig_hit[a]) begin
              st_r[a]   <= ST_RUN;
              pen_r[a]  <= 1'b1;
              go_r[a]   <= 1'b1;
              move_r[a] <= ind_mv[a];
              prof_r[a] <= step_profile[a];
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ssp_ok;
    pos_sync_start_request && ssp_err == STAT_OK;
  endsequence
  sequence s_armed(int a);
    st_r[a] == ST_ARMED;
  endsequence

  property p_ptv;
    pos_to_vel_request && st_r[ax] == ST_RUN && !gen_done[ax]
    |=> vel_r[$past(ax)] && move_r == $past(move_r);
  endproperty
  a_ptv: assert property (p_ptv) else $error("velocity switch");

  property p_stop;
    decel_stop_request && st_r[ax] == ST_RUN && !dec_zero
    |=> st_r[$past(ax)] == ST_DECEL && dreq_r[$past(ax)]
        ##1 !dreq_r[$past(ax, 2)];
  endproperty
  a_stop: assert property (p_stop) else $error("decel stop");

  property p_stop0;
    decel_stop_request && st_r[ax] == ST_RUN && dec_zero
    |=> !pen_r[$past(ax)] && st_r[$past(ax)] == ST_IDLE
        && !dreq_r[$past(ax)];
  endproperty
  a_stop0: assert property (p_stop0) else $error("zero stop");

  property p_prof;
    st_r[0] == ST_IDLE && (ist_rise[0] || dst_rise[0]) && !ssp_a[0]
    |=> prof_r[0] == ($past(dst_rise[0]) ? $past(dst_profile[0])
                                          : $past(step_profile[0]));
  endproperty
  a_prof: assert property (p_prof) else $error("profile");

  property p_nodone;
    st_r[0] == ST_DECEL && gen_done[0]
    |=> !pdone_r[0] && !mcode_r[0] && $stable(step_r[0]);
  endproperty
  a_nodone: assert property (p_nodone) else $error("stop done");

  property p_abs;
    st_r[0] == ST_IDLE && ist_rise[0] && !dst_rise[0] && !ssp_a[0]
    |=> move_r[0] == ($past(step_abs[0])
        ? $past(step_target[0]) - $past(cur_pos[0])
        : $past(step_target[0]));
  endproperty
  a_abs: assert property (p_abs) else $error("restart move");

  property p_arm;
    s_ssp_ok |=> st_r[$past(ax)] == ST_ARMED
      && main_r[$past(ax)] == $past(main_axis_select);
  endproperty
  a_arm: assert property (p_arm) else $error("sync arm");

  property p_wait;
    s_armed(1) |-> y_in_operation_flag && !pulse_enable[1];
  endproperty
  a_wait: assert property (p_wait) else $error("armed wait");

  property p_same;
    pos_sync_start_request && !bad_main && main_axis_select == ax
    |=> cmd_done && cmd_status == ERR_SAME
        && st_r[$past(ax)] == $past(st_r[ax]);
  endproperty
  a_same: assert property (p_same) else $error("same axis");

  property p_busy_main;
    pos_sync_start_request && !bad_main && main_axis_select != ax
    && st_r[main_axis_select] == ST_ARMED
    |=> cmd_status == ERR_MAIN_SUB;
  endproperty
  a_busy_main: assert property (p_busy_main) else $error("main armed");

  property p_org;
    pos_sync_start_request && ssp_err != ERR_MAIN_RNG
    && ssp_err != ERR_SAME && ssp_err != ERR_MAIN_SUB
    && !origin_ok[main_axis_select]
    |=> cmd_status == ERR_MAIN_ORG;
  endproperty
  a_org: assert property (p_org) else $error("origin");

  property p_done;
    cmd_any |=> cmd_done ##1 !cmd_done;
  endproperty
  a_done: assert property (p_done) else $error("done pulse");
endmodule : amssc_top

// ---- hdl/amssc_pkg.sv ----
// Constants and types for the axis mode, stop and sync command block
package amssc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_DECEL     = 8'h04;
  localparam logic [7:0]  A_SYNC      = 8'h08;
  localparam logic [7:0]  A_TRIG      = 8'h0C;
  localparam logic [7:0]  A_STAT      = 8'h10;
  localparam logic [7:0]  A_FLAGS     = 8'h14;
  localparam int          CTRL_PTV    = 0;
  localparam int          CTRL_STP    = 1;
  localparam int          CTRL_SSP    = 2;
  localparam int          CTRL_AXIS   = 4;
  localparam int          SYNC_MAIN   = 8;
  localparam logic [6:0]  STEP_MAX    = 7'h50;
  localparam logic [15:0] DEC_RST     = 16'h0000;
  // ---------------------------------------------------------------
  // Status codes
  // ---------------------------------------------------------------
  localparam logic [15:0] STAT_OK      = 16'h0000;
  localparam logic [15:0] ERR_SUB_ORG  = 16'h0158;
  localparam logic [15:0] ERR_MAIN_ORG = 16'h015A;
  localparam logic [15:0] ERR_SAME     = 16'h015B;
  localparam logic [15:0] ERR_MAIN_SUB = 16'h015D;
  localparam logic [15:0] ERR_MAIN_RNG = 16'h015E;
  localparam logic [15:0] ERR_SUB_BUSY = 16'h015F;
  // Axis run state
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_DECEL = 2'b10,
    ST_ARMED = 2'b11
  } amssc_st_t;
endpackage : amssc_pkg

// ---- testbench/amssc_pgen.sv ----
// Pulse generator model that moves both axis positions
module amssc_pgen #(
  parameter int RAMP = 6
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [1:0]       pulse_enable,
  input  wire logic [1:0]       decel_start,
  input  wire logic [1:0][31:0] move_amount,
  output logic      [1:0][31:0] cur_pos,
  output logic      [1:0]       gen_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0][31:0] left_r;
  logic [1:0][3:0]  ramp_r;
  logic [1:0]       en_q;
  // One pulse a cycle; a ramp holds position and ends with done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_pos  <= '0;
      left_r   <= '0;
      ramp_r   <= '0;
      en_q     <= '0;
      gen_done <= '0;
    end else begin
      en_q <= pulse_enable;
      for (int i = 0; i < 2; i++) begin
        gen_done[i] <= 1'b0;
        if (decel_start[i]) begin
          ramp_r[i] <= 4'(RAMP);
        end else if (ramp_r[i] != 4'h0) begin
          ramp_r[i]   <= ramp_r[i] - 4'h1;
          gen_done[i] <= (ramp_r[i] == 4'h1);
        end else if (pulse_enable[i] && !en_q[i]) begin
          left_r[i] <= move_amount[i];
        end else if (pulse_enable[i] && left_r[i] != 32'h0) begin
          cur_pos[i]  <= cur_pos[i] + 32'h1;
          left_r[i]   <= left_r[i] - 32'h1;
          gen_done[i] <= (left_r[i] == 32'h1);
        end
      end
    end
  end
endmodule : amssc_pgen

// ---- testbench/axis_mode_stop_sync_control_test.sv ----
// Bench for the axis command block driven over its register bus
module axis_mode_stop_sync_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import amssc_pkg::*;
  // ----------
  // Signals
  // ----------
  logic             pclk, pready, pslverr, done, ok;
  logic             xpc, ypc, xop, yop, xpd, ypd;
  logic             presetn = 1'b0;
  logic             psel    = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite  = 1'b0;
  logic [7:0]       paddr   = 8'h00;
  logic [31:0]      pwdata  = 32'h0000_0000;
  logic [1:0]       indirect_start_request = 2'b00;
  logic [1:0]       direct_start_request   = 2'b00;
  logic [1:0]       org     = 2'b11;
  logic [1:0]       sabs    = 2'b11;
  logic [1:0]       smc     = 2'b11;
  logic [1:0][31:0] target  = {32'h0000_0190, 32'h0000_012C};
  logic [1:0][3:0]  sprof   = {4'h5, 4'h3};
  logic [1:0][31:0] dst_amt = '0;
  logic [1:0][3:0]  dprof   = '0;
  logic [1:0]       gdone, mcode, pen, dstart, go;
  logic [1:0][31:0] cur_pos, mv;
  logic [1:0][3:0]  prof;
  logic [1:0][6:0]  step;
  logic [15:0]      status, dtime;
  logic [31:0]      got, pos;
  int               failures, compares, n;
  // Sync cases: control, select, origins, expected status
  logic [31:0] sctl [6] = '{32'h0000_0014, 32'h0000_0014, 32'h0000_0014,
                            32'h0000_0014, 32'h0000_0014, 32'h0000_0004};
  logic [31:0] ssel [6] = '{32'h0000_0150, 32'h0000_0050, 32'h0000_0050,
                            32'h0000_0250, 32'h0000_0050, 32'h0000_0150};
  logic [1:0]  sorg [6] = '{2'b11, 2'b10, 2'b01, 2'b11, 2'b11, 2'b11};
  logic [15:0] sst  [6] = '{16'h015B, 16'h015A, 16'h0158,
                            16'h015E, 16'h0000, 16'h015D};

  amssc_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(got),
    .pready(pready), .pslverr(pslverr),
    .indirect_start_request(indirect_start_request),
    .direct_start_request(direct_start_request), .origin_ok(org),
    .cur_pos(cur_pos), .step_target(target), .step_abs(sabs),
    .step_profile(sprof), .step_mcode(smc), .dst_amount(dst_amt),
    .dst_profile(dprof), .gen_done(gdone), .cmd_done(done),
    .cmd_status(status), .x_pos_control_flag(xpc),
    .y_pos_control_flag(ypc), .x_in_operation_flag(xop),
    .y_in_operation_flag(yop), .x_positioning_done_flag(xpd),
    .y_positioning_done_flag(ypd), .m_code_on(mcode),
    .pulse_enable(pen), .decel_start(dstart), .decel_time(dtime),
    .accdec_profile(prof), .sync_go(go), .cur_step(step),
    .move_amount(mv)
  );
  amssc_pgen #(.RAMP(6)) PGEN (
    .pclk(pclk), .presetn(presetn), .pulse_enable(pen),
    .decel_start(dstart), .move_amount(mv), .cur_pos(cur_pos),
    .gen_done(gdone)
  );
  // ----------
  // Tasks
  // ----------
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %s got %h", $time, m, g);
    end
  endtask : chk
  // Setup, access until pready at a rising edge, data taken there, one idle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = got;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x, m);
  endtask : rd
  // Clear then raise a request; answer stands after the idle edge
  task automatic cmd(input logic [31:0] c, input logic [15:0] st,
                     input logic [1:0] ds);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, c);
    @(negedge pclk);
    chk(done, 1'b1, "done");
    chk(status, st, "status");
    chk(dstart, ds, "ramp start");
    @(posedge pclk);
  endtask : cmd
  task automatic start(input int i);
    indirect_start_request[i] <= 1'b1;
    repeat (3) @(posedge pclk);
    indirect_start_request[i] <= 1'b0;
  endtask : start
  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // ----------
  // Tests
  // ----------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_STAT, 32'h0000_0000, "stat");
    rd(A_FLAGS, 32'h0000_0000, "flags");
    apb(1'b0, 8'h18, 32'h0000_0000, pos, ok);
    chk(ok, 1'b1, "slverr");
    // Position run switched to velocity, then halted at once
    start(0);
    @(negedge pclk);
    chk(mv[0], 32'h0000_012C, "abs move");
    @(posedge pclk);
    rd(A_FLAGS, 32'h0000_0005, "run flags");
    if (xpc === 1'b1) cmd(32'h0000_0001, 16'h0000, 2'b00);
    @(negedge pclk);
    chk(xpc, 1'b0, "vel mode");
    chk(pen[0], 1'b1, "still on");
    @(posedge pclk);
    wr(A_DECEL, 32'h0000_0000);
    cmd(32'h0000_0002, 16'h0000, 2'b00);
    @(negedge pclk);
    chk(pen[0], 1'b0, "at once");
    chk(xop, 1'b0, "idle");
    pos = cur_pos[0];
    @(posedge pclk);
    // Absolute restart moves the rest; ramp stop leaves no completion
    start(0);
    @(negedge pclk);
    chk(mv[0], 32'h0000_012C - pos, "rest");
    @(posedge pclk);
    wr(A_DECEL, 32'h0000_0010);
    cmd(32'h0000_0002, 16'h0000, 2'b01);
    @(negedge pclk);
    chk(dtime, 32'h0000_0010, "ramp time");
    chk(prof[0], 32'h0000_0003, "ramp prof");
    for (n = 0; n < 20 && pen[0] !== 1'b0; n++) @(negedge pclk);
    chk(pen[0], 1'b0, "ramp end");
    chk(xpd, 1'b0, "no done");
    chk(mcode[0], 1'b0, "no m code");
    chk(step[0], 7'h00, "step kept");
    @(posedge pclk);
    sabs[0] <= 1'b0;
    start(0);
    @(negedge pclk);
    chk(mv[0], 32'h0000_012C, "full move");
    for (n = 0; n < 400 && xpd !== 1'b1; n++) @(negedge pclk);
    chk(mcode[0], 1'b1, "m code");
    chk(step[0], 7'h01, "step on");
    pos = cur_pos[0] + 32'h0000_0014;
    @(posedge pclk);
    wr(A_DECEL, 32'h0000_FFFF);
    rd(A_DECEL, 32'h0000_FFFF, "decel max");
    wr(A_TRIG, 32'h8000_0000);
    rd(A_TRIG, 32'h8000_0000, "trig min");
    wr(A_TRIG, pos);
    // Sync refusals, arm Y on X, then refuse a sync of X on the armed Y
    for (int i = 0; i < 6; i++) begin
      org <= sorg[i];
      wr(A_SYNC, ssel[i]);
      cmd(sctl[i], sst[i], 2'b00);
    end
    @(negedge pclk);
    chk(yop, 1'b1, "armed busy");
    chk(pen[1], 1'b0, "armed quiet");
    chk(ypc, 1'b1, "armed pos mode");
    @(posedge pclk);
    start(0);
    for (n = 0; n < 80 && go[1] !== 1'b1; n++) @(negedge pclk);
    chk(go[1], 1'b1, "trigger");
    chk(step[1], 7'h50, "sync step");
    chk(mv[1], 32'h0000_0190, "sync move");
    @(posedge pclk);
    cmd(32'h0000_0012, 16'h0000, 2'b10);
    @(negedge pclk);
    chk(prof[1], 32'h0000_0005, "y prof");
    chk(ypd, 1'b0, "y no done");
    chk(mcode[1], 1'b0, "y no m code");
    summarize();
  end
endmodule : axis_mode_stop_sync_control_test
